// ---- msp_chk_sva.sv ----
// assertion checker for the motor start profile block
`timescale 1ns/1ps
module msp_chk import msp_pkg::*; (
    input wire logic i_clk, // clock
    input wire logic i_srst, // reset
    input wire logic i_thermal_trip, // thermal over limit
    input wire logic i_saved_trip, // retained trip
    input wire logic o_run_enable, // fire enable
    input wire logic o_ol_trip, // trip latched
    input wire logic [4:0] o_ol_class, // class in force
    input wire logic o_ramp_set, // ramp set
    input wire logic o_ramp_current, // current ramp
    input wire logic [DW-1:0] o_init_torque, // initial torque
    input wire logic [DW-1:0] o_accel_time, // accel time
    input wire logic [DW-1:0] o_current_ceiling // ceiling
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    class_range_a: assert property (o_ol_class >= 5'h05 && o_ol_class <= 5'h1e)
        else $error("overload class out of range");
    set_hold_a: assert property (o_run_enable && $past(o_run_enable) |-> $stable(o_ramp_set))
        else $error("ramp set moved during a start");
    set_latch_a: assert property ($changed(o_ramp_set) |-> $rose(o_run_enable))
        else $error("ramp set changed without a start");
    time_range_a: assert property (o_accel_time >= 16'h0001 && o_accel_time <= 16'h0078)
        else $error("accel time out of range");
    ceil_range_a: assert property (o_current_ceiling <= 16'h0258)
        else $error("ceiling out of range");
    volt_range_a: assert property (!o_ramp_current |-> o_init_torque <= 16'h0064)
        else $error("initial voltage out of range");
    trip_cause_a: assert property ($rose(o_ol_trip) |-> $past(i_thermal_trip) || $past(i_saved_trip))
        else $error("trip without cause");
    start_notrip_a: assert property ($rose(o_run_enable) |-> !$past(o_ol_trip))
        else $error("start while tripped");
    trip_stop_a: assert property (o_ol_trip && $past(o_ol_trip, 2) |-> !o_run_enable)
        else $error("running while tripped");
endmodule
bind msp_top msp_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_thermal_trip(i_thermal_trip),
    .i_saved_trip(i_saved_trip), .o_run_enable(o_run_enable), .o_ol_trip(o_ol_trip), .o_ol_class(o_ol_class),
    .o_ramp_set(o_ramp_set), .o_ramp_current(o_ramp_current), .o_init_torque(o_init_torque),
    .o_accel_time(o_accel_time), .o_current_ceiling(o_current_ceiling));

// ---- msp_motor_model.sv ----
// behavioural motor with thermal model
`timescale 1ns/1ps
module msp_motor_model #(parameter int SPIN = 20, parameter int COOL = 30) (
    input wire logic i_clk, // clock
    input wire logic i_srst, // reset
    input wire logic i_run, // thyristors firing
    input wire logic i_heat, // overheat command
    output logic o_full_speed, // at speed
    output logic o_thermal_trip, // over limit
    output logic o_thermal_ok // cooled
);
    int spin_q;
    int cool_q;
    always_ff @(posedge i_clk) begin
        spin_q <= (i_srst || !i_run) ? 0 : spin_q + 1;
        cool_q <= (i_srst || i_heat) ? 0 : (cool_q < COOL ? cool_q + 1 : cool_q);
    end
    assign o_full_speed = i_run && spin_q >= SPIN;
    assign o_thermal_trip = i_heat;
    assign o_thermal_ok = cool_q >= COOL;
endmodule

// ---- msp_ovl_ctl.sv ----
// overload trip latch with the three reset policies
`timescale 1ns/1ps
module msp_ovl_ctl import msp_pkg::*; (
    input wire logic i_clk,          // system clock
    input wire logic i_srst,         // sync reset
    input wire logic i_ce,           // clock enable
    input wire logic i_boot,         // first enabled cycle after reset
    input wire logic i_saved_trip,   // trip retained across power loss
    input wire logic i_trip_event,   // thermal model demands a trip
    input wire logic [1:0] i_policy, // reset policy
    input wire logic i_thermal_ok,   // windings cooled enough
    input wire logic i_reset_press,  // reset key pressed, pulse
    output logic o_trip              // trip latched
);
    logic trip_q;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            trip_q <= 1'b0;
        end else if (i_ce) begin
            if (i_trip_event && i_policy != POL_OFF) begin
                trip_q <= 1'b1;
            end else if (i_boot) begin
                trip_q <= i_saved_trip && !(i_policy == POL_AUTO && i_thermal_ok);
            end else if (trip_q) begin
                if (i_policy == POL_OFF) begin
                    trip_q <= 1'b0;
                end else if (i_thermal_ok && i_policy == POL_AUTO) begin
                    trip_q <= 1'b0;
                end else if (i_thermal_ok && i_reset_press) begin
                    trip_q <= 1'b0;
                end
            end
        end
    end

    assign o_trip = trip_q;
endmodule

// ---- msp_pkg.sv ----
// constants, register map and limits of the motor start profile block
package msp_pkg;
    localparam int DW = 16;
    localparam int AW = 4;
    localparam int NCFG = 14;
    localparam int NPIN = 5;
    // configuration and status register indices
    localparam logic [AW-1:0] IDX_RATED = 4'h0;
    localparam logic [AW-1:0] IDX_MARGIN = 4'h1;
    localparam logic [AW-1:0] IDX_START_CLASS = 4'h2;
    localparam logic [AW-1:0] IDX_RUN_CLASS = 4'h3;
    localparam logic [AW-1:0] IDX_POLICY = 4'h4;
    localparam logic [AW-1:0] IDX_PROFILE = 4'h5;
    localparam logic [AW-1:0] IDX_R1_INIT_V = 4'h6;
    localparam logic [AW-1:0] IDX_R1_INIT_I = 4'h7;
    localparam logic [AW-1:0] IDX_R1_TIME = 4'h8;
    localparam logic [AW-1:0] IDX_R1_CEIL = 4'h9;
    localparam logic [AW-1:0] IDX_R2_INIT_V = 4'ha;
    localparam logic [AW-1:0] IDX_R2_INIT_I = 4'hb;
    localparam logic [AW-1:0] IDX_R2_TIME = 4'hc;
    localparam logic [AW-1:0] IDX_R2_CEIL = 4'hd;
    localparam logic [AW-1:0] IDX_STATUS = 4'he;
    // limits and reset values, indexed as above
    localparam logic [DW-1:0] CFG_MIN [NCFG] = '{16'h0032, 16'h0064, 16'h0005, 16'h0005, 16'h0000, 16'h0001,
        16'h0000, 16'h0000, 16'h0001, 16'h00c8, 16'h0000, 16'h0000, 16'h0001, 16'h00c8};
    localparam logic [DW-1:0] CFG_MAX [NCFG] = '{16'h0064, 16'h0082, 16'h001e, 16'h001e, 16'h0002, 16'h0004,
        16'h0064, 16'h0258, 16'h0078, 16'h0258, 16'h0064, 16'h0258, 16'h0078, 16'h0258};
    localparam logic [DW-1:0] CFG_DEF [NCFG] = '{16'h0000, 16'h0064, 16'h000a, 16'h000a, 16'h0000, 16'h0001,
        16'h003c, 16'h00c8, 16'h000a, 16'h015e, 16'h003c, 16'h00c8, 16'h000a, 16'h015e};
    // service factor in hundredths; rated ceiling is twice unity minus factor
    localparam logic [DW-1:0] MARGIN_TWICE_UNITY = 16'h00c8;
    localparam logic [2*DW-1:0] PCT_FULL = 32'h0000_0064;
    localparam logic [DW-1:0] RATED_UNSET = 16'h0000;
    // reset policies and profiles
    localparam logic [1:0] POL_MANUAL = 2'h0;
    localparam logic [1:0] POL_AUTO = 2'h1;
    localparam logic [1:0] POL_OFF = 2'h2;
    localparam logic [DW-1:0] PROF_VV = 16'h0001;
    localparam logic [DW-1:0] PROF_CC = 16'h0002;
    localparam logic [DW-1:0] PROF_VC = 16'h0003;
    localparam logic [DW-1:0] PROF_CV = 16'h0004;
    // synchronised pin positions
    localparam int PIN_START = 0;
    localparam int PIN_STOP = 1;
    localparam int PIN_TWO_WIRE = 2;
    localparam int PIN_DUAL = 3;
    localparam int PIN_RESET_KEY = 4;
    // status register fields
    localparam int ST_BIT_TRIP = 0;
    localparam int ST_BIT_SET = 1;
    localparam int ST_BIT_RATED_OK = 2;
    localparam int ST_BIT_REJECT = 3;
    localparam int ST_BIT_RUN = 4;
    localparam int ST_BIT_FULL = 5;
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_RUN, ST_TRIP} msp_state_t;
endpackage

// ---- msp_ramp_sel.sv ----
// picks the active ramp set and its scaled parameters
`timescale 1ns/1ps
module msp_ramp_sel import msp_pkg::*; (
    input wire logic [DW-1:0] i_profile,  // ramp profile select
    input wire logic i_set,               // 0 ramp one, 1 ramp two
    input wire logic [DW-1:0] i_rated,    // rated current, % of unit max
    input wire logic [DW-1:0] i_r1_v,     // ramp one initial voltage
    input wire logic [DW-1:0] i_r1_i,     // ramp one initial current
    input wire logic [DW-1:0] i_r1_t,     // ramp one accel time
    input wire logic [DW-1:0] i_r1_c,     // ramp one current ceiling
    input wire logic [DW-1:0] i_r2_v,     // ramp two initial voltage
    input wire logic [DW-1:0] i_r2_i,     // ramp two initial current
    input wire logic [DW-1:0] i_r2_t,     // ramp two accel time
    input wire logic [DW-1:0] i_r2_c,     // ramp two current ceiling
    output logic o_is_current,            // active ramp is current type
    output logic [DW-1:0] o_init,         // initial torque value
    output logic [DW-1:0] o_time,         // accel time, seconds
    output logic [DW-1:0] o_ceil          // ceiling, % of unit max
);
    function automatic logic ramp_is_current(input logic [DW-1:0] prof, input logic set);
        if (!set) begin
            ramp_is_current = (prof == PROF_CC) || (prof == PROF_CV);
        end else begin
            ramp_is_current = (prof == PROF_CC) || (prof == PROF_VC);
        end
    endfunction

    function automatic logic [DW-1:0] scale(input logic [DW-1:0] pct, input logic [DW-1:0] rated);
        logic [2*DW-1:0] prod;
        prod = pct * rated;
        scale = DW'(prod / PCT_FULL);
    endfunction

    always_comb begin
        o_is_current = ramp_is_current(i_profile, i_set);
        // the other set's fields are never looked at
        if (!i_set) begin
            o_init = o_is_current ? scale(i_r1_i, i_rated) : i_r1_v;
            o_time = i_r1_t;
            o_ceil = scale(i_r1_c, i_rated);
        end else begin
            o_init = o_is_current ? scale(i_r2_i, i_rated) : i_r2_v;
            o_time = i_r2_t;
            o_ceil = scale(i_r2_c, i_rated);
        end
    end
endmodule

// ---- msp_tb.sv ----
// self-checking testbench for the motor start profile block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 300) begin @(posedge i_clk); k++; end \
    if (!(c)) err_total++; end
module tb import msp_pkg::*;;
    logic i_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, heat = 0, ce = 1;
    logic [AW-1:0] i_addr = '0;
    logic [DW-1:0] i_wdata = '0, o_rdata, o_init_torque, o_accel_time, o_current_ceiling, ex;
    logic i_start_cmd = 0, i_stop_cmd = 0, i_two_wire = 1, i_dual_ramp = 0, i_reset_key = 0, i_saved_trip = 0;
    logic i_full_speed, i_thermal_trip, i_thermal_ok, o_run_enable, o_ol_trip, o_ramp_set, o_ramp_current, c;
    logic [4:0] o_ol_class;
    int err_total = 0, n_compared = 0, k, cyc = 0;
    always #5 i_clk = ~i_clk;
    msp_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_start_cmd(i_start_cmd), .i_stop_cmd(i_stop_cmd), .i_two_wire(i_two_wire),
        .i_dual_ramp(i_dual_ramp), .i_reset_key(i_reset_key), .i_full_speed(i_full_speed),
        .i_thermal_trip(i_thermal_trip), .i_thermal_ok(i_thermal_ok), .i_saved_trip(i_saved_trip),
        .o_run_enable(o_run_enable), .o_ol_trip(o_ol_trip), .o_ol_class(o_ol_class), .o_ramp_set(o_ramp_set),
        .o_ramp_current(o_ramp_current), .o_init_torque(o_init_torque), .o_accel_time(o_accel_time),
        .o_current_ceiling(o_current_ceiling));
    msp_motor_model u_motor (.i_clk(i_clk), .i_srst(i_srst), .i_run(o_run_enable), .i_heat(heat),
        .o_full_speed(i_full_speed), .o_thermal_trip(i_thermal_trip), .o_thermal_ok(i_thermal_ok));
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge i_clk); i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk); i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge i_clk); i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk); i_rd <= 1'b0;
        #1 `CHK(o_rdata, e)
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    // table of write attempts: index, value, value read back
    logic [AW-1:0] ta [12] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h0, 4'h1, 4'h2, 4'h2, 4'h9, 4'h3};
    logic [DW-1:0] tv [12] = '{16'h0031, 16'h0065, 16'h0064, 16'h0073, 16'h0055, 16'h0073, 16'h0056, 16'h0083,
        16'h0004, 16'h001f, 16'h00c7, 16'h0014};
    logic [DW-1:0] te [12] = '{16'h0000, 16'h0000, 16'h0064, 16'h0064, 16'h0055, 16'h0073, 16'h0055, 16'h0073,
        16'h000a, 16'h000a, 16'h015e, 16'h0014};
    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < NCFG; i++) rd(i[AW-1:0], CFG_DEF[i]);
        rd(4'hf, 16'h0000);
        $display("test defaults done");
        i_start_cmd <= 1'b1;
        repeat (20) @(posedge i_clk);
        `CHK(o_run_enable, 1'b0)
        i_start_cmd <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            wr(ta[i], tv[i]);
            rd(ta[i], te[i]);
        end
        rd(IDX_STATUS, 16'h000c);
        rd(IDX_STATUS, 16'h0004);
        ce <= 1'b0;
        wr(IDX_RUN_CLASS, 16'h001e);
        ce <= 1'b1;
        rd(IDX_RUN_CLASS, 16'h0014);
        $display("test ranges done");
        wr(IDX_R2_INIT_V, 16'h0028); wr(IDX_R2_INIT_I, 16'h012c); wr(IDX_R2_TIME, 16'h0014);
        wr(IDX_R2_CEIL, 16'h0190);
        for (int p = 1; p <= 4; p++) for (int d = 0; d < 2; d++) begin
            i_dual_ramp <= d[0];
            wr(IDX_PROFILE, 16'(p));
            i_start_cmd <= 1'b1;
            `WAIT(o_run_enable)
            repeat (2) @(posedge i_clk);
            c = d ? (p == 2 || p == 3) : (p == 2 || p == 4);
            ex = c ? 16'((d ? 300 : 200) * 85 / 100) : 16'(d ? 40 : 60);
            `CHK(o_ramp_set, d[0])
            `CHK(o_ramp_current, c)
            `CHK(o_init_torque, ex)
            `CHK(o_accel_time, 16'(d ? 20 : 10))
            `CHK(o_current_ceiling, 16'((d ? 400 : 350) * 85 / 100))
            `CHK(o_ol_class, 5'h0a)
            i_dual_ramp <= !d[0];
            `WAIT(i_full_speed)
            repeat (2) @(posedge i_clk);
            `CHK(o_ol_class, 5'h14)
            `CHK(o_ramp_set, d[0])
            i_start_cmd <= 1'b0;
            `WAIT(!o_run_enable)
        end
        $display("test profiles done");
        i_two_wire <= 1'b0;
        i_start_cmd <= 1'b1;
        repeat (8) @(posedge i_clk);
        `CHK(o_run_enable, 1'b1)
        i_stop_cmd <= 1'b1;
        repeat (6) @(posedge i_clk);
        `CHK(o_run_enable, 1'b0)
        i_stop_cmd <= 1'b0;
        repeat (6) @(posedge i_clk);
        `CHK(o_run_enable, 1'b0)
        i_two_wire <= 1'b1;
        $display("test three-wire done");
        i_start_cmd <= 1'b1;
        for (int pol = 0; pol < 3; pol++) begin
            wr(IDX_POLICY, 16'(pol));
            `WAIT(o_run_enable)
            heat <= 1'b1;
            repeat (3) @(posedge i_clk);
            heat <= 1'b0;
            `CHK(o_ol_trip, pol != 2)
            `WAIT(i_thermal_ok)
            repeat (12) @(posedge i_clk);
            `CHK(o_ol_trip, pol == 0)
            i_reset_key <= 1'b1;
            `WAIT(!o_ol_trip && o_run_enable)
            `CHK(o_run_enable, 1'b1)
            i_reset_key <= 1'b0;
        end
        $display("test policies done");
        i_saved_trip <= 1'b1;
        i_srst <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        repeat (5) @(posedge i_clk);
        `CHK(o_ol_trip, 1'b1)
        `CHK(o_run_enable, 1'b0)
        $display("test power cycle done");
        close_out();
    end
endmodule

// ---- msp_top.sv ----
// motor start profile and overload configuration, top level
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module msp_top import msp_pkg::*; (
    input wire logic i_clk,                   // system clock, 100 MHz
    input wire logic i_srst,                  // sync reset, active high
    input wire logic i_ce,                    // clock enable, freezes state low
    input wire logic [AW-1:0] i_addr,         // register index
    input wire logic [DW-1:0] i_wdata,        // write data
    input wire logic i_wr,                    // write strobe
    input wire logic i_rd,                    // read strobe
    output logic [DW-1:0] o_rdata,            // read data, cycle after strobe
    input wire logic i_start_cmd,             // start pin
    input wire logic i_stop_cmd,              // stop pin, three-wire
    input wire logic i_two_wire,              // maintained control mode pin
    input wire logic i_dual_ramp,             // dual-ramp pin
    input wire logic i_reset_key,             // reset key pin
    input wire logic i_full_speed,            // motor at full speed
    input wire logic i_thermal_trip,          // thermal model over limit
    input wire logic i_thermal_ok,            // thermal capacity recovered
    input wire logic i_saved_trip,            // retained trip from last power-up
    output logic o_run_enable,                // thyristors may fire
    output logic o_ol_trip,                   // overload trip latched
    output logic [4:0] o_ol_class,            // overload class in force
    output logic o_ramp_set,                  // 0 ramp one, 1 ramp two
    output logic o_ramp_current,              // active ramp is current type
    output logic [DW-1:0] o_init_torque,      // initial voltage % or current
    output logic [DW-1:0] o_accel_time,       // accel time, seconds
    output logic [DW-1:0] o_current_ceiling   // ceiling, % of unit max
);

    // ********************************************************
    // declarations
    // ********************************************************
    logic [DW-1:0] cfg_q [NCFG];
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta_q;
    logic [NPIN-1:0] pin_q;
    logic start_prev_q;
    logic key_prev_q;
    logic boot_done_q;
    logic reject_q;
    logic set_q;
    msp_state_t state_q;
    msp_state_t state_d;
    logic start_rise;
    logic key_press;
    logic boot;
    logic rated_ok;
    logic trip;
    logic start_req;
    logic stop_req;
    logic start_accept;
    logic wr_cfg;
    logic wr_ok;
    logic rd_status;
    logic sel_is_current;
    logic [DW-1:0] sel_init;
    logic [DW-1:0] sel_time;
    logic [DW-1:0] sel_ceil;
    logic [DW-1:0] status;
    logic [DW-1:0] rdata_d;
    logic [DW-1:0] rdata_q;
    logic run_en_q;
    logic [4:0] class_q;
    logic ramp_cur_q;
    logic [DW-1:0] init_q;
    logic [DW-1:0] time_q;
    logic [DW-1:0] ceil_q;

    // ********************************************************
    // helper functions
    // ********************************************************
    function automatic logic is_cfg(input logic [AW-1:0] addr);
        is_cfg = addr <= IDX_R2_CEIL;
    endfunction

    // range check plus the rated current versus service factor bound
    function automatic logic cfg_ok(input logic [AW-1:0] idx, input logic [DW-1:0] val,
                                    input logic [DW-1:0] rated, input logic [DW-1:0] margin);
        cfg_ok = 1'b1;
        if (val < CFG_MIN[idx] || val > CFG_MAX[idx]) begin
            cfg_ok = 1'b0;
        end
        if (idx == IDX_RATED && val > MARGIN_TWICE_UNITY - margin) begin
            cfg_ok = 1'b0;
        end
        if (idx == IDX_MARGIN && rated > MARGIN_TWICE_UNITY - val) begin
            cfg_ok = 1'b0;
        end
    endfunction

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    assign pin_raw[PIN_START] = i_start_cmd;
    assign pin_raw[PIN_STOP] = i_stop_cmd;
    assign pin_raw[PIN_TWO_WIRE] = i_two_wire;
    assign pin_raw[PIN_DUAL] = i_dual_ramp;
    assign pin_raw[PIN_RESET_KEY] = i_reset_key;

    generate
        for (genvar g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    pin_meta_q[g] <= 1'b0;
                    pin_q[g] <= 1'b0;
                end else if (i_ce) begin
                    pin_meta_q[g] <= pin_raw[g];
                    pin_q[g] <= pin_meta_q[g];
                end
            end
        end
    endgenerate

    // ********************************************************
    // edge detection and power-up marker
    // ********************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            start_prev_q <= 1'b0;
            key_prev_q <= 1'b0;
        end else if (i_ce) begin
            start_prev_q <= pin_q[PIN_START];
            key_prev_q <= pin_q[PIN_RESET_KEY];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            boot_done_q <= 1'b0;
        end else if (i_ce) begin
            boot_done_q <= 1'b1;
        end
    end

    assign start_rise = pin_q[PIN_START] && !start_prev_q;
    assign key_press = pin_q[PIN_RESET_KEY] && !key_prev_q;
    assign boot = i_ce && !boot_done_q;

    // ********************************************************
    // configuration registers
    // ********************************************************
    assign wr_cfg = i_wr && is_cfg(i_addr);
    assign wr_ok = wr_cfg && cfg_ok(i_addr, i_wdata, cfg_q[IDX_RATED], cfg_q[IDX_MARGIN]);

    generate
        for (genvar r = 0; r < NCFG; r++) begin : g_cfg
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    cfg_q[r] <= CFG_DEF[r];
                end else if (i_ce && wr_ok && i_addr == AW'(r)) begin
                    cfg_q[r] <= i_wdata;
                end
            end
        end
    endgenerate

    // sticky flag for a refused write, cleared by reading status
    assign rd_status = i_rd && i_addr == IDX_STATUS;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            reject_q <= 1'b0;
        end else if (i_ce) begin
            if (wr_cfg && !wr_ok) begin
                reject_q <= 1'b1;
            end else if (rd_status) begin
                reject_q <= 1'b0;
            end
        end
    end

    assign rated_ok = cfg_q[IDX_RATED] != RATED_UNSET;

    // ********************************************************
    // overload trip latch
    // ********************************************************
    msp_ovl_ctl u_ovl (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_boot(boot),
        .i_saved_trip(i_saved_trip),
        .i_trip_event(i_thermal_trip),
        .i_policy(cfg_q[IDX_POLICY][1:0]),
        .i_thermal_ok(i_thermal_ok),
        .i_reset_press(key_press),
        .o_trip(trip)
    );

    // ********************************************************
    // start sequencing
    // ********************************************************
    // maintained control starts on level, momentary control on edge
    assign start_req = pin_q[PIN_TWO_WIRE] ? pin_q[PIN_START] : start_rise;
    assign stop_req = pin_q[PIN_TWO_WIRE] ? !pin_q[PIN_START] : pin_q[PIN_STOP];
    assign start_accept = state_q == ST_IDLE && start_req && !stop_req && rated_ok && !trip;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (trip) begin
                    state_d = ST_TRIP;
                end else if (start_accept) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                if (trip) begin
                    state_d = ST_TRIP;
                end else if (stop_req || !rated_ok) begin
                    state_d = ST_IDLE;
                end else if (i_full_speed) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (trip) begin
                    state_d = ST_TRIP;
                end else if (stop_req || !rated_ok) begin
                    state_d = ST_IDLE;
                end
            end
            ST_TRIP: begin
                if (!trip) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= ST_IDLE;
        end else if (i_ce) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            set_q <= 1'b0;
        end else if (i_ce && start_accept) begin
            set_q <= pin_q[PIN_DUAL];
        end
    end

    // ********************************************************
    // ramp parameter selection
    // ********************************************************
    msp_ramp_sel u_ramp (
        .i_profile(cfg_q[IDX_PROFILE]),
        .i_set(set_q),
        .i_rated(cfg_q[IDX_RATED]),
        .i_r1_v(cfg_q[IDX_R1_INIT_V]),
        .i_r1_i(cfg_q[IDX_R1_INIT_I]),
        .i_r1_t(cfg_q[IDX_R1_TIME]),
        .i_r1_c(cfg_q[IDX_R1_CEIL]),
        .i_r2_v(cfg_q[IDX_R2_INIT_V]),
        .i_r2_i(cfg_q[IDX_R2_INIT_I]),
        .i_r2_t(cfg_q[IDX_R2_TIME]),
        .i_r2_c(cfg_q[IDX_R2_CEIL]),
        .o_is_current(sel_is_current),
        .o_init(sel_init),
        .o_time(sel_time),
        .o_ceil(sel_ceil)
    );

    // ********************************************************
    // registered outputs
    // ********************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            run_en_q <= 1'b0;
            class_q <= CFG_DEF[IDX_START_CLASS][4:0];
        end else if (i_ce) begin
            run_en_q <= (state_d == ST_START || state_d == ST_RUN) && rated_ok;
            if (state_d == ST_RUN) begin
                class_q <= cfg_q[IDX_RUN_CLASS][4:0];
            end else begin
                class_q <= cfg_q[IDX_START_CLASS][4:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ramp_cur_q <= 1'b0;
            init_q <= CFG_DEF[IDX_R1_INIT_V];
            time_q <= CFG_DEF[IDX_R1_TIME];
            ceil_q <= RATED_UNSET;
        end else if (i_ce) begin
            ramp_cur_q <= sel_is_current;
            init_q <= sel_init;
            time_q <= sel_time;
            ceil_q <= sel_ceil;
        end
    end

    // ********************************************************
    // register read port
    // ********************************************************
    always_comb begin
        status = '0;
        status[ST_BIT_TRIP] = trip;
        status[ST_BIT_SET] = set_q;
        status[ST_BIT_RATED_OK] = rated_ok;
        status[ST_BIT_REJECT] = reject_q;
        status[ST_BIT_RUN] = state_q == ST_START || state_q == ST_RUN;
        status[ST_BIT_FULL] = state_q == ST_RUN;
    end

    always_comb begin
        rdata_d = '0;
        if (i_rd) begin
            if (is_cfg(i_addr)) begin
                rdata_d = cfg_q[i_addr];
            end else if (i_addr == IDX_STATUS) begin
                rdata_d = status;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_q <= '0;
        end else if (i_ce) begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_run_enable = run_en_q;
    assign o_ol_trip = trip;
    assign o_ol_class = class_q;
    assign o_ramp_set = set_q;
    assign o_ramp_current = ramp_cur_q;
    assign o_init_torque = init_q;
    assign o_accel_time = time_q;
    assign o_current_ceiling = ceil_q;
endmodule
